// >>> rtl/sbp_pkg.sv
// Constants, field positions, command codes and types of the status and block protection logic.
// Assumes a 25-bit byte address space of 512 sectors of 64KB each.
package sbp_pkg;

    // Status register fields.
    localparam int SR_SRWD = 7;
    localparam int SR_BP3  = 6;
    localparam int SR_TB   = 5;
    localparam int SR_BP2  = 4;
    localparam int SR_BP1  = 3;
    localparam int SR_BP0  = 2;
    localparam int SR_WEL  = 1;
    localparam int SR_WIP  = 0;

    // Flag status register fields.
    localparam int FSR_READY     = 7;
    localparam int FSR_ERASE_ERR = 5;
    localparam int FSR_PROG_ERR  = 4;
    localparam int FSR_PROT_ERR  = 1;

    // Reset values.
    localparam logic       SRWD_RESET = 1'b0;
    localparam logic       TB_RESET   = 1'b0;
    localparam logic [3:0] BP_RESET   = 4'h0;
    localparam logic       WEL_RESET  = 1'b0;

    // Array geometry.
    localparam int         ADDR_BITS    = 25;
    localparam int         SECTOR_LSB   = 16;
    localparam int         SECTOR_BITS  = 9;
    localparam logic [9:0] SECTOR_COUNT = 10'h200;
    localparam logic [3:0] BP_ALL_CODE  = 4'hA;
    localparam logic [2:0] ADDR_BYTES   = 3'h4;

    // Command codes.
    localparam logic [7:0] CMD_WRITE_STATUS = 8'h01;
    localparam logic [7:0] CMD_PROGRAM      = 8'h02;
    localparam logic [7:0] CMD_WRITE_DIS    = 8'h04;
    localparam logic [7:0] CMD_READ_STATUS  = 8'h05;
    localparam logic [7:0] CMD_WRITE_EN     = 8'h06;
    localparam logic [7:0] CMD_SUB4_ERASE   = 8'h20;
    localparam logic [7:0] CMD_CLEAR_FLAGS  = 8'h50;
    localparam logic [7:0] CMD_SUB32_ERASE  = 8'h52;
    localparam logic [7:0] CMD_READ_FLAGS   = 8'h70;
    localparam logic [7:0] CMD_BULK_ERASE   = 8'hC7;
    localparam logic [7:0] CMD_SECT_ERASE   = 8'hD8;

    // Timing of an internal write cycle.
    localparam int BUSY_TIME_NS  = 4000;
    localparam int CLK_PERIOD_NS = 4;
    localparam int BUSY_CYCLES   = (BUSY_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int BUSY_CNT_BITS = 16;

    typedef enum logic [1:0] {
        ST_CMD  = 2'b00,
        ST_ADDR = 2'b01,
        ST_DATA = 2'b11,
        ST_OUT  = 2'b10
    } sbp_state_t;

    typedef enum logic [2:0] {
        OP_PROGRAM = 3'h0,
        OP_SUB4    = 3'h1,
        OP_SUB32   = 3'h2,
        OP_SECTOR  = 3'h3,
        OP_BULK    = 3'h4
    } sbp_op_t;

endpackage : sbp_pkg

// >>> rtl/sbp_range_if.sv
// Interface between the command logic and the protected range checker.
// Assumes both ends sit in the same clock domain.
interface sbp_range_if;
    logic [3:0] code;
    logic       bottom;
    logic [8:0] sector;
    logic       hit;
    logic       any_on;

    modport requester (output code, output bottom, output sector, input hit, input any_on);
    modport judge     (input code, input bottom, input sector, output hit, output any_on);
endinterface : sbp_range_if

// >>> rtl/sbp_range_check.sv
// Protected range checker: decides whether a sector lies in the block-protected area.
// Assumes a stable code and sector from the requester; purely combinational.
module sbp_range_check (
    sbp_range_if.judge chk
);
    logic [9:0] span;
    logic [9:0] sector_w;

    always_comb
    begin
        sector_w = {1'b0, chk.sector};
        if (chk.code == 4'h0)
        begin
            span = 10'h000;
        end
        else if (chk.code >= sbp_pkg::BP_ALL_CODE)
        begin
            span = sbp_pkg::SECTOR_COUNT;
        end
        else
        begin
            span = 10'(10'h001 << (chk.code - 4'h1));
        end
    end

    // A top range counts down from the last sector, a bottom range up from sector 0.
    assign chk.hit    = chk.bottom ? (sector_w < span) : (sector_w >= 10'(sbp_pkg::SECTOR_COUNT - span));
    assign chk.any_on = (chk.code != 4'h0);

endmodule : sbp_range_check

// >>> rtl/sbp_status_guard.sv
// Status register and block write protection of a serial flash, seen from the serial pins.
// Assumes the serial clock, select, data and protect pins are asynchronous to i_clock and slow
// enough (period 125 ns) to be sampled; i_quad_mode is a level from logic on i_clock.
module sbp_status_guard #(
    parameter int BUSY_CYCLES = sbp_pkg::BUSY_CYCLES
) (
    input  wire logic        i_clock,
    input  wire logic        i_rst_n,
    input  wire logic        i_cs_n,
    input  wire logic        i_sclk,
    input  wire logic        i_mosi,
    input  wire logic        i_data_line_two,
    input  wire logic        i_quad_mode,
    output logic             o_miso,
    output logic             o_miso_oe,
    output logic             o_data_line_two,
    output logic             o_data_line_two_oe,
    output logic             o_op_valid,
    output logic [2:0]       o_op_kind,
    output logic [24:0]      o_op_addr,
    output logic             o_busy
);
    localparam logic [15:0] BUSY_LOAD = 16'(BUSY_CYCLES);

    logic        cs_s1_ff, cs_s2_ff, cs_d3_ff;
    logic        sclk_s1_ff, sclk_s2_ff, sclk_d3_ff;
    logic        mosi_s1_ff, mosi_s2_ff;
    logic        wp_s1_ff, wp_s2_ff;
    logic        sclk_rise, sclk_fall, frame_end;

    sbp_pkg::sbp_state_t state_ff, nxt_state;
    logic [2:0]  bit_cnt_ff, nxt_bit_cnt;
    logic [7:0]  shift_ff, nxt_shift;
    logic [7:0]  opcode_ff, nxt_opcode;
    logic [24:0] addr_ff, nxt_addr;
    logic [2:0]  addr_cnt_ff, nxt_addr_cnt;
    logic        got_data_ff, nxt_got_data;
    logic [7:0]  wrsr_val_ff, nxt_wrsr_val;
    logic [2:0]  out_idx_ff, nxt_out_idx;
    logic        miso_ff, nxt_miso;
    logic        srwd_ff, nxt_srwd;
    logic        tb_ff, nxt_tb;
    logic [3:0]  bp_ff, nxt_bp;
    logic        wel_ff, nxt_wel;
    logic [15:0] busy_cnt_ff, nxt_busy_cnt;
    logic        err_erase_ff, nxt_err_erase;
    logic        err_prog_ff, nxt_err_prog;
    logic        err_prot_ff, nxt_err_prot;
    logic        op_valid_ff, nxt_op_valid;
    logic [2:0]  op_kind_ff, nxt_op_kind;
    logic [24:0] op_addr_ff, nxt_op_addr;

    logic [7:0]  byte_in;
    logic [7:0]  status_byte, flag_byte;
    logic        busy, ready, locked, out_bit, addr_done, is_array_op;
    logic [24:0] full_addr;

    sbp_range_if rng ();

    sbp_range_check u_range (
        .chk (rng.judge)
    );

    // The first stage of each synchroniser feeds only the second.
    always_ff @(posedge i_clock)
    begin
        if (!i_rst_n)
        begin
            cs_s1_ff   <= 1'b1;
            cs_s2_ff   <= 1'b1;
            cs_d3_ff   <= 1'b1;
            sclk_s1_ff <= 1'b0;
            sclk_s2_ff <= 1'b0;
            sclk_d3_ff <= 1'b0;
            mosi_s1_ff <= 1'b0;
            mosi_s2_ff <= 1'b0;
            wp_s1_ff   <= 1'b1;
            wp_s2_ff   <= 1'b1;
        end
        else
        begin
            cs_s1_ff   <= i_cs_n;
            cs_s2_ff   <= cs_s1_ff;
            cs_d3_ff   <= cs_s2_ff;
            sclk_s1_ff <= i_sclk;
            sclk_s2_ff <= sclk_s1_ff;
            sclk_d3_ff <= sclk_s2_ff;
            mosi_s1_ff <= i_mosi;
            mosi_s2_ff <= mosi_s1_ff;
            wp_s1_ff   <= i_data_line_two;
            wp_s2_ff   <= wp_s1_ff;
        end
    end

    assign sclk_rise = sclk_s2_ff & ~sclk_d3_ff;
    assign sclk_fall = ~sclk_s2_ff & sclk_d3_ff;
    assign frame_end = cs_s2_ff & ~cs_d3_ff;
    assign byte_in   = {shift_ff[6:0], mosi_s2_ff};

    assign busy  = (busy_cnt_ff != 16'h0000);
    assign ready = ~busy;
    // In quad mode the pin is a data line, so it never locks the register.
    assign locked = srwd_ff & ~wp_s2_ff & ~i_quad_mode;

    always_comb
    begin
        status_byte                     = 8'h00;
        status_byte[sbp_pkg::SR_SRWD]   = srwd_ff;
        status_byte[sbp_pkg::SR_BP3]    = bp_ff[3];
        status_byte[sbp_pkg::SR_TB]     = tb_ff;
        status_byte[sbp_pkg::SR_BP2]    = bp_ff[2];
        status_byte[sbp_pkg::SR_BP1]    = bp_ff[1];
        status_byte[sbp_pkg::SR_BP0]    = bp_ff[0];
        status_byte[sbp_pkg::SR_WEL]    = wel_ff;
        status_byte[sbp_pkg::SR_WIP]    = ~ready;
        flag_byte                       = 8'h00;
        flag_byte[sbp_pkg::FSR_READY]     = ready;
        flag_byte[sbp_pkg::FSR_ERASE_ERR] = err_erase_ff;
        flag_byte[sbp_pkg::FSR_PROG_ERR]  = err_prog_ff;
        flag_byte[sbp_pkg::FSR_PROT_ERR]  = err_prot_ff;
    end

    assign out_bit = (opcode_ff == sbp_pkg::CMD_READ_STATUS) ? status_byte[3'h7 - out_idx_ff]
                                                             : flag_byte[3'h7 - out_idx_ff];

    // The address register keeps the low 25 bits of the four address bytes.
    assign full_addr   = addr_ff;
    assign addr_done   = (addr_cnt_ff == sbp_pkg::ADDR_BYTES);
    assign is_array_op = (opcode_ff == sbp_pkg::CMD_PROGRAM) || (opcode_ff == sbp_pkg::CMD_SUB4_ERASE) ||
                         (opcode_ff == sbp_pkg::CMD_SUB32_ERASE) || (opcode_ff == sbp_pkg::CMD_SECT_ERASE);

    assign rng.code   = bp_ff;
    assign rng.bottom = tb_ff;
    assign rng.sector = addr_ff[sbp_pkg::SECTOR_LSB +: sbp_pkg::SECTOR_BITS];

    always_comb
    begin
        nxt_state     = state_ff;
        nxt_bit_cnt   = bit_cnt_ff;
        nxt_shift     = shift_ff;
        nxt_opcode    = opcode_ff;
        nxt_addr      = addr_ff;
        nxt_addr_cnt  = addr_cnt_ff;
        nxt_got_data  = got_data_ff;
        nxt_wrsr_val  = wrsr_val_ff;
        nxt_out_idx   = out_idx_ff;
        nxt_miso      = miso_ff;
        nxt_srwd      = srwd_ff;
        nxt_tb        = tb_ff;
        nxt_bp        = bp_ff;
        nxt_wel       = wel_ff;
        nxt_busy_cnt  = busy ? (busy_cnt_ff - 16'h0001) : busy_cnt_ff;
        nxt_err_erase = err_erase_ff;
        nxt_err_prog  = err_prog_ff;
        nxt_err_prot  = err_prot_ff;
        nxt_op_valid  = 1'b0;
        nxt_op_kind   = op_kind_ff;
        nxt_op_addr   = op_addr_ff;
        // The latch drops when an internal write cycle ends.
        if (busy_cnt_ff == 16'h0001)
        begin
            nxt_wel = 1'b0;
        end
        // Commands act at the end of a whole-byte frame; only reads are served while busy.
        if (frame_end && (bit_cnt_ff == 3'h0) && !busy)
        begin
            if (opcode_ff == sbp_pkg::CMD_WRITE_EN)
            begin
                nxt_wel = 1'b1;
            end
            else if (opcode_ff == sbp_pkg::CMD_WRITE_DIS)
            begin
                nxt_wel = 1'b0;
            end
            else if (opcode_ff == sbp_pkg::CMD_CLEAR_FLAGS)
            begin
                nxt_err_erase = 1'b0;
                nxt_err_prog  = 1'b0;
                nxt_err_prot  = 1'b0;
            end
            else if ((opcode_ff == sbp_pkg::CMD_WRITE_STATUS) && wel_ff && got_data_ff && !locked)
            begin
                nxt_srwd     = wrsr_val_ff[sbp_pkg::SR_SRWD];
                nxt_tb       = wrsr_val_ff[sbp_pkg::SR_TB];
                nxt_bp       = {wrsr_val_ff[sbp_pkg::SR_BP3], wrsr_val_ff[sbp_pkg::SR_BP2],
                                wrsr_val_ff[sbp_pkg::SR_BP1], wrsr_val_ff[sbp_pkg::SR_BP0]};
                nxt_busy_cnt = BUSY_LOAD;
            end
            else if (is_array_op && wel_ff && addr_done)
            begin
                if (rng.hit)
                begin
                    nxt_err_prot = 1'b1;
                    nxt_wel      = 1'b0;
                    if (opcode_ff == sbp_pkg::CMD_PROGRAM)
                    begin
                        nxt_err_prog = 1'b1;
                    end
                    else
                    begin
                        nxt_err_erase = 1'b1;
                    end
                end
                else
                begin
                    nxt_op_valid = 1'b1;
                    nxt_op_addr  = full_addr;
                    nxt_busy_cnt = BUSY_LOAD;
                    case (opcode_ff)
                        sbp_pkg::CMD_PROGRAM:     nxt_op_kind = sbp_pkg::OP_PROGRAM;
                        sbp_pkg::CMD_SUB4_ERASE:  nxt_op_kind = sbp_pkg::OP_SUB4;
                        sbp_pkg::CMD_SUB32_ERASE: nxt_op_kind = sbp_pkg::OP_SUB32;
                        default:                  nxt_op_kind = sbp_pkg::OP_SECTOR;
                    endcase
                end
            end
            else if ((opcode_ff == sbp_pkg::CMD_BULK_ERASE) && wel_ff)
            begin
                if (rng.any_on)
                begin
                    nxt_err_erase = 1'b1;
                    nxt_err_prot  = 1'b1;
                    nxt_wel       = 1'b0;
                end
                else
                begin
                    nxt_op_valid = 1'b1;
                    nxt_op_kind  = sbp_pkg::OP_BULK;
                    nxt_op_addr  = 25'h0000000;
                    nxt_busy_cnt = BUSY_LOAD;
                end
            end
        end
        if (cs_s2_ff)
        begin
            nxt_state    = sbp_pkg::ST_CMD;
            nxt_bit_cnt  = 3'h0;
            // An empty frame must not replay the previous command.
            nxt_opcode   = 8'h00;
            nxt_addr_cnt = 3'h0;
            nxt_got_data = 1'b0;
            nxt_out_idx  = 3'h0;
        end
        else
        begin
            if (sclk_rise)
            begin
                nxt_shift   = byte_in;
                nxt_bit_cnt = bit_cnt_ff + 3'h1;
                if (bit_cnt_ff == 3'h7)
                begin
                    case (state_ff)
                        sbp_pkg::ST_CMD:
                        begin
                            nxt_opcode = byte_in;
                            if ((byte_in == sbp_pkg::CMD_READ_STATUS) || (byte_in == sbp_pkg::CMD_READ_FLAGS))
                            begin
                                nxt_state = sbp_pkg::ST_OUT;
                            end
                            else if ((byte_in == sbp_pkg::CMD_PROGRAM) || (byte_in == sbp_pkg::CMD_SUB4_ERASE) ||
                                     (byte_in == sbp_pkg::CMD_SUB32_ERASE) || (byte_in == sbp_pkg::CMD_SECT_ERASE))
                            begin
                                nxt_state = sbp_pkg::ST_ADDR;
                            end
                            else
                            begin
                                nxt_state = sbp_pkg::ST_DATA;
                            end
                        end
                        sbp_pkg::ST_ADDR:
                        begin
                            nxt_addr     = {addr_ff[16:0], byte_in};
                            nxt_addr_cnt = addr_cnt_ff + 3'h1;
                            if (addr_cnt_ff == (sbp_pkg::ADDR_BYTES - 3'h1))
                            begin
                                nxt_state = sbp_pkg::ST_DATA;
                            end
                        end
                        sbp_pkg::ST_DATA:
                        begin
                            if (!got_data_ff)
                            begin
                                nxt_wrsr_val = byte_in;
                                nxt_got_data = 1'b1;
                            end
                        end
                        default:
                        begin
                            nxt_state = state_ff;
                        end
                    endcase
                end
            end
            if (sclk_fall && (state_ff == sbp_pkg::ST_OUT))
            begin
                nxt_miso    = out_bit;
                nxt_out_idx = out_idx_ff + 3'h1;
            end
        end
    end

    always_ff @(posedge i_clock)
    begin
        if (!i_rst_n)
        begin
            state_ff     <= sbp_pkg::ST_CMD;
            bit_cnt_ff   <= 3'h0;
            shift_ff     <= 8'h00;
            opcode_ff    <= 8'h00;
            addr_ff      <= 25'h0000000;
            addr_cnt_ff  <= 3'h0;
            got_data_ff  <= 1'b0;
            wrsr_val_ff  <= 8'h00;
            out_idx_ff   <= 3'h0;
            miso_ff      <= 1'b0;
            srwd_ff      <= sbp_pkg::SRWD_RESET;
            tb_ff        <= sbp_pkg::TB_RESET;
            bp_ff        <= sbp_pkg::BP_RESET;
            wel_ff       <= sbp_pkg::WEL_RESET;
            busy_cnt_ff  <= 16'h0000;
            err_erase_ff <= 1'b0;
            err_prog_ff  <= 1'b0;
            err_prot_ff  <= 1'b0;
            op_valid_ff  <= 1'b0;
            op_kind_ff   <= 3'h0;
            op_addr_ff   <= 25'h0000000;
        end
        else
        begin
            state_ff     <= nxt_state;
            bit_cnt_ff   <= nxt_bit_cnt;
            shift_ff     <= nxt_shift;
            opcode_ff    <= nxt_opcode;
            addr_ff      <= nxt_addr;
            addr_cnt_ff  <= nxt_addr_cnt;
            got_data_ff  <= nxt_got_data;
            wrsr_val_ff  <= nxt_wrsr_val;
            out_idx_ff   <= nxt_out_idx;
            miso_ff      <= nxt_miso;
            srwd_ff      <= nxt_srwd;
            tb_ff        <= nxt_tb;
            bp_ff        <= nxt_bp;
            wel_ff       <= nxt_wel;
            busy_cnt_ff  <= nxt_busy_cnt;
            err_erase_ff <= nxt_err_erase;
            err_prog_ff  <= nxt_err_prog;
            err_prot_ff  <= nxt_err_prot;
            op_valid_ff  <= nxt_op_valid;
            op_kind_ff   <= nxt_op_kind;
            op_addr_ff   <= nxt_op_addr;
        end
    end

    assign o_miso             = miso_ff;
    assign o_miso_oe          = (state_ff == sbp_pkg::ST_OUT) & ~cs_s2_ff;
    assign o_data_line_two    = miso_ff;
    assign o_data_line_two_oe = i_quad_mode & o_miso_oe;
    assign o_op_valid         = op_valid_ff;
    assign o_op_kind          = op_kind_ff;
    assign o_op_addr          = op_addr_ff;
    assign o_busy             = busy;

    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_rst_n);

    property p_read_bit;
        (sclk_fall && !cs_s2_ff && (state_ff == sbp_pkg::ST_OUT) && (opcode_ff == sbp_pkg::CMD_READ_STATUS))
            |=> (miso_ff == $past(status_byte[3'h7 - out_idx_ff]));
    endproperty
    a_read_bit: assert property (p_read_bit) else $error("Status bit shifted out wrong.");

    property p_locked_hold;
        (frame_end && (bit_cnt_ff == 3'h0) && !busy && (opcode_ff == sbp_pkg::CMD_WRITE_STATUS) && locked)
            |=> ($stable(bp_ff) && $stable(srwd_ff) && $stable(tb_ff) && !busy);
    endproperty
    a_locked_hold: assert property (p_locked_hold) else $error("Locked status register changed.");

    property p_unlocked_write;
        (frame_end && (bit_cnt_ff == 3'h0) && !busy && wel_ff && got_data_ff && !locked &&
         (opcode_ff == sbp_pkg::CMD_WRITE_STATUS))
            |=> ((srwd_ff == $past(wrsr_val_ff[7])) && (tb_ff == $past(wrsr_val_ff[5]))) ##0 busy[*8];
    endproperty
    a_unlocked_write: assert property (p_unlocked_write) else $error("Status write not taken.");

    property p_top_one;
        (!rng.bottom && (rng.code == 4'h1)) |-> (rng.hit == (rng.sector == 9'h1FF));
    endproperty
    a_top_one: assert property (p_top_one) else $error("Top single sector range wrong.");

    property p_bottom_nine;
        (rng.bottom && (rng.code == 4'h9)) |-> (rng.hit == (rng.sector < 9'h100));
    endproperty
    a_bottom_nine: assert property (p_bottom_nine) else $error("Bottom half range wrong.");

    property p_all_codes;
        (rng.code >= 4'hA) |-> rng.hit;
    endproperty
    a_all_codes: assert property (p_all_codes) else $error("Full range code missed a sector.");

    property p_bulk_refused;
        (frame_end && (opcode_ff == sbp_pkg::CMD_BULK_ERASE) && (bp_ff != 4'h0)) |=> !op_valid_ff;
    endproperty
    a_bulk_refused: assert property (p_bulk_refused) else $error("Bulk erase ran with protection.");

    property p_write_enable;
        (frame_end && (bit_cnt_ff == 3'h0) && !busy && (opcode_ff == sbp_pkg::CMD_WRITE_EN)) |=> wel_ff;
    endproperty
    a_write_enable: assert property (p_write_enable) else $error("Write enable not latched.");

    property p_busy_flags;
        status_byte[0] == ~flag_byte[7];
    endproperty
    a_busy_flags: assert property (p_busy_flags) else $error("Busy and ready disagree.");

    property p_protected_refused;
        (frame_end && (bit_cnt_ff == 3'h0) && !busy && wel_ff && is_array_op && addr_done && rng.hit)
            |=> (!op_valid_ff && err_prot_ff && !wel_ff) ##1 !op_valid_ff;
    endproperty
    a_protected_refused: assert property (p_protected_refused) else $error("Protected sector not refused.");

    c_status_write: cover property (frame_end && (opcode_ff == sbp_pkg::CMD_WRITE_STATUS) && !locked && wel_ff);
    c_refused:      cover property ($rose(err_prot_ff));
    c_bulk:         cover property (op_valid_ff && (op_kind_ff == sbp_pkg::OP_BULK));
    c_read:         cover property (sclk_fall && (state_ff == sbp_pkg::ST_OUT));

endmodule : sbp_status_guard

// >>> verification/sbp_host.sv
// Serial host model that drives command frames on the select, clock and data pins.
// Assumes a link clock period of 125 ns; the link clock stands low between frames.
module sbp_host (
    output logic      o_cs_n,
    output logic      o_sclk,
    output logic      o_mosi,
    input  wire logic i_miso
);
    timeunit 1ns;
    timeprecision 100ps;
    initial
    begin
        o_cs_n = 1'b1;
        o_sclk = 1'b0;
        o_mosi = 1'b0;
    end
    // Shifts n bits out MSB first; rx returns the last eight bits taken from miso.
    task automatic frame(input logic [39:0] tx, input int n, output logic [7:0] rx);
        o_cs_n = 1'b0;
        #100;
        for (int i = n - 1; i >= 0; i--)
        begin
            o_mosi = tx[i];
            #62.5 o_sclk = 1'b1;
            rx = {rx[6:0], i_miso};
            #62.5 o_sclk = 1'b0;
        end
        #100 o_cs_n = 1'b1;
        // The data line no longer carries the last bit once the device is deselected.
        o_mosi = ~o_mosi;
        #200;
    endtask : frame
endmodule : sbp_host

// >>> verification/status_and_block_protection_tb.sv
// Self-checking bench of the status register and block protection logic.
// Assumes the host model on the serial pins and a protect pin driven by the bench.
module status_and_block_protection_tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic        i_clock = 1'b0;
    logic        i_rst_n = 1'b0;
    logic        wp      = 1'b1;
    logic        quad    = 1'b0;
    logic        cs_n, sclk, mosi, miso, op_valid, busy, oe, dq2, dq2_oe;
    logic [2:0]  kind;
    logic [24:0] addr;
    logic [7:0]  rx;
    int          n_fail = 0, tests_run = 0, cyc = 0, n_op = 0, n_oe = 0, n_q = 0, n_dq2 = 0;
    sbp_host host (.o_cs_n(cs_n), .o_sclk(sclk), .o_mosi(mosi), .i_miso(miso));
    sbp_status_guard #(.BUSY_CYCLES(800)) dut (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_cs_n(cs_n),
        .i_sclk(sclk), .i_mosi(mosi), .i_data_line_two(wp), .i_quad_mode(quad), .o_miso(miso),
        .o_miso_oe(oe), .o_data_line_two(dq2), .o_data_line_two_oe(dq2_oe), .o_op_valid(op_valid),
        .o_op_kind(kind), .o_op_addr(addr), .o_busy(busy));
    always #2 i_clock = ~i_clock;
    always @(posedge i_clock)
    begin
        cyc++;
        if (op_valid === 1'b1)
            n_op++;
        if (oe === 1'b1)
            n_oe++;
        if (dq2_oe === 1'b1)
            n_q++;
        if (dq2 !== miso)
            n_dq2++;
        if (cyc == 80000)
        begin
            n_fail++;
            give_verdict;
        end
    end
    task automatic give_verdict;
        $display("n_fail %0d tests_run %0d", n_fail, tests_run);
        if (n_fail == 0 && tests_run > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : give_verdict
    task automatic chk(input string s, input logic [24:0] e, input logic [24:0] g);
        tests_run++;
        if (g !== e)
        begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", s, e, g);
        end
    endtask : chk
    task automatic idle;
        for (int i = 0; i < 2000 && busy !== 1'b0; i++)
            @(negedge i_clock);
    endtask : idle
    task automatic rd(input logic [7:0] e);
        int o0, q0;
        o0 = n_oe;
        q0 = n_q;
        host.frame(40'h0500, 16, rx);
        chk("status", e, rx);
        chk("miso_oe", 1'b1, n_oe > o0);
        chk("dq2_oe", quad, n_q > q0);
        chk("dq2", 1'b1, n_dq2 == 0);
    endtask : rd
    task automatic rf(input logic [7:0] e);
        host.frame(40'h7000, 16, rx);
        chk("flags", e, rx);
    endtask : rf
    // Write enable, then a status write; ok says whether it must start a write cycle.
    task automatic wr(input logic [7:0] v, input logic ok);
        host.frame(40'h06, 8, rx);
        host.frame({24'h0, 8'h01, v}, 16, rx);
        chk("busy", ok, busy);
        idle;
    endtask : wr
    task automatic er(input logic [7:0] c, input logic [8:0] s, input logic ok);
        int         n0;
        logic [2:0] k;
        n0 = n_op;
        k  = (c == 8'hC7) ? 3'h4 : (c == 8'h02) ? 3'h0 : (c == 8'h20) ? 3'h1 : (c == 8'h52) ? 3'h2 : 3'h3;
        host.frame(40'h06, 8, rx);
        host.frame({c, 7'h0, s, 16'h0}, 40, rx);
        chk("op", ok, n_op - n0 == 1);
        if (ok)
        begin
            chk("addr", {s, 16'h0}, addr);
            chk("kind", k, kind);
        end
        idle;
    endtask : er
    initial
    begin
        repeat (12) @(negedge i_clock);
        i_rst_n = 1'b1;
        rd(8'h00);
        host.frame(40'h06, 8, rx);
        rd(8'h02);
        wr(8'h24, 1'b1);
        rd(8'h24);
        er(8'hD8, 9'h000, 1'b0);
        rf(8'hA2);
        host.frame(40'h50, 8, rx);
        rf(8'h80);
        er(8'hD8, 9'h001, 1'b1);
        wr(8'h1C, 1'b1);
        er(8'hD8, 9'h1C0, 1'b0);
        er(8'hD8, 9'h1BF, 1'b1);
        er(8'h02, 9'h000, 1'b1);
        er(8'h02, 9'h1FF, 1'b0);
        rf(8'hB2);
        er(8'h20, 9'h1C0, 1'b0);
        er(8'h52, 9'h005, 1'b1);
        er(8'hC7, 9'h000, 1'b0);
        wr(8'h68, 1'b1);
        er(8'hD8, 9'h1FF, 1'b0);
        wr(8'h80, 1'b1);
        @(negedge i_clock) wp = 1'b0;
        wr(8'h00, 1'b0);
        @(negedge i_clock) quad = 1'b1;
        wr(8'h80, 1'b1);
        rd(8'h80);
        @(negedge i_clock) quad = 1'b0;
        wr(8'h00, 1'b0);
        @(negedge i_clock) wp = 1'b1;
        wr(8'h00, 1'b1);
        rd(8'h00);
        er(8'hC7, 9'h000, 1'b1);
        give_verdict;
    end
endmodule : status_and_block_protection_tb
